/* common/aia_pkg.sv */
// Purpose: shared constants and types for the axis interrupt aggregator
// Assumes: four axes, register port with one-cycle read latency
// Notes: register map offsets are local to this block
package aia_pkg;
	localparam int AIA_AXES = 4;
	localparam int AIA_ERR_W = 17;
	localparam int AIA_EVT_W = 20;
	localparam int AIA_ADDR_W = 6;
	localparam int AIA_DATA_W = 32;

	// Per-axis register offsets; axis base is axis * AIA_AXIS_STRIDE
	localparam logic [5:0] AIA_AXIS_STRIDE = 6'h10;
	localparam logic [3:0] AIA_OFF_STATUS = 4'h0;
	localparam logic [3:0] AIA_OFF_ERRCAUSE = 4'h4;
	localparam logic [3:0] AIA_OFF_EVTCAUSE = 4'h8;
	localparam logic [3:0] AIA_OFF_CMD = 4'hC;
	localparam logic [3:0] AIA_OFF_CFG = 4'h1;
	localparam logic [3:0] AIA_OFF_ENABLE = 4'h2;
	// Address and command field positions
	localparam int AIA_AXIS_MSB = 5;
	localparam int AIA_AXIS_LSB = 4;
	localparam int AIA_OFF_MSB = 3;
	localparam int AIA_CMD_MSB = 7;
	// Configuration base at address zero, inside the axis area
	localparam logic [5:0] AIA_OFF_CFG_BASE = 6'h00;

	// Main-status bit positions
	localparam int AIA_ST_STOP = 2;
	localparam int AIA_ST_ERR = 4;
	localparam int AIA_ST_EVT = 5;
	localparam int AIA_ST_COMP = 6;
	// Configuration bit positions
	localparam int AIA_CFG_CAUSE_INH = 23;
	localparam int AIA_CFG_STAT_INH = 25;
	localparam int AIA_CFG_STOP_EN = 27;
	localparam int AIA_CFG_PIN_MASK = 29;
	localparam int AIA_CFG_SUPPRESS = 7;

	// Command codes written to the command offset
	localparam logic [7:0] AIA_CMD_STOP_CLR = 8'h2D;
	localparam logic [7:0] AIA_CMD_COMP_CLR = 8'h2E;
	localparam logic [7:0] AIA_CMD_ERR_READ = 8'hF2;
	localparam logic [7:0] AIA_CMD_EVT_READ = 8'hF3;

	localparam logic [1:0] AIA_PFM_DONE_A = 2'h2;
	localparam logic [1:0] AIA_PFM_DONE_B = 2'h3;

	localparam logic [31:0] AIA_ZERO = 32'h0000_0000;

	typedef struct packed {
		logic [AIA_ERR_W-1:0] errCond;
		logic [AIA_EVT_W-1:0] evtCond;
		logic opStop;
		logic compEvent;
		logic [1:0] preregisterState;
	} aia_axis_ev_t;

	typedef struct packed {
		logic [AIA_ADDR_W-1:0] addr;
		logic [AIA_DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} aia_bus_t;
endpackage

/* core/aia_aggregator.sv */
// Purpose: per-axis interrupt causes combined onto one active-low pin
// Assumes: event inputs synchronous to clk, one-cycle pulses
// Notes: config words per axis share the axis address space
`timescale 1ns/10ps
module aia_aggregator
	import aia_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire aia_axis_ev_t axisEv [AIA_AXES],
	input wire aia_bus_t bus,
	output logic [AIA_DATA_W-1:0] rdata,
	output logic ioBuffer_valid,
	output logic [AIA_DATA_W-1:0] ioBuffer,
	output logic irq_n,
	output logic irq
);
	// Address layout: axis index in the upper bits, offset in the lower
	function automatic logic [1:0] axisOf(input logic [AIA_ADDR_W-1:0] a);
		return a[AIA_AXIS_MSB:AIA_AXIS_LSB];
	endfunction

	function automatic logic [3:0] offOf(input logic [AIA_ADDR_W-1:0] a);
		return a[AIA_OFF_MSB:0];
	endfunction

	function automatic logic hit(input logic [AIA_ADDR_W-1:0] a, input int ax,
		input logic [3:0] off);
		return (axisOf(a) == 2'(ax)) && (offOf(a) == off);
	endfunction

	// Command code sits in the low byte of the write data
	function automatic logic [7:0] cmdOf(input logic [AIA_DATA_W-1:0] w);
		return w[AIA_CMD_MSB:0];
	endfunction

	// Stops inside a chained run carry a loaded pre-register state
	function automatic logic contStopOf(input logic suppress, input logic [1:0] preregister_state);
		return suppress && (preregister_state == AIA_PFM_DONE_A || preregister_state == AIA_PFM_DONE_B);
	endfunction

	function automatic logic [AIA_DATA_W-1:0] errWord(input logic [AIA_ERR_W-1:0] c);
		return AIA_DATA_W'(c);
	endfunction

	function automatic logic [AIA_DATA_W-1:0] evtWord(input logic [AIA_EVT_W-1:0] c);
		return AIA_DATA_W'(c);
	endfunction

	logic [AIA_ERR_W-1:0] errCause_reg [AIA_AXES];
	logic [AIA_EVT_W-1:0] evtCause_reg [AIA_AXES];
	logic [AIA_EVT_W-1:0] evtEnable_reg [AIA_AXES];
	logic [AIA_DATA_W-1:0] cfg_reg [AIA_AXES];
	logic [AIA_AXES-1:0] stopFlag_reg;
	logic [AIA_AXES-1:0] compFlag_reg;
	logic [AIA_AXES-1:0] statusRead_reg;
	logic [AIA_AXES-1:0] errSummary;
	logic [AIA_AXES-1:0] evtSummary;
	logic [AIA_AXES-1:0] pend;
	logic irqNext;
	logic [AIA_DATA_W-1:0] rdata_next;
	logic [AIA_DATA_W-1:0] ioBuffer_next;
	logic ioBufferValid_next;
	logic [AIA_DATA_W-1:0] statusSel;
	logic [1:0] busAxis;
	logic [3:0] busOff;
	logic [7:0] busCmd;
	logic cmdWr;

	// Shared decode of the register port
	assign busAxis = axisOf(bus.addr);
	assign busOff = offOf(bus.addr);
	assign busCmd = cmdOf(bus.wdata);
	assign cmdWr = bus.wr && (busOff == AIA_OFF_CMD);

	genvar g;
	generate
		for (g = 0; g < AIA_AXES; g++) begin : gAxis
			logic cfgWr;
			logic enableWr;
			logic errW1c;
			logic evtW1c;
			logic cmdHit;
			logic errReadCmd;
			logic evtReadCmd;
			logic stopClrCmd;
			logic compClrCmd;
			logic statusRd;
			logic causeInh;
			logic statInh;
			logic stopEn;
			logic suppress;
			logic autoClr;
			logic setStop;
			logic [AIA_ERR_W-1:0] errClr;
			logic [AIA_EVT_W-1:0] evtClr;
			logic [AIA_ERR_W-1:0] errCause_next;
			logic [AIA_EVT_W-1:0] evtCause_next;
			logic stopFlag_next;
			logic compFlag_next;

			assign cfgWr = bus.wr && hit(bus.addr, g, AIA_OFF_CFG);
			assign enableWr = bus.wr && hit(bus.addr, g, AIA_OFF_ENABLE);
			assign errW1c = bus.wr && hit(bus.addr, g, AIA_OFF_ERRCAUSE);
			assign evtW1c = bus.wr && hit(bus.addr, g, AIA_OFF_EVTCAUSE);
			assign cmdHit = bus.wr && hit(bus.addr, g, AIA_OFF_CMD);
			assign errReadCmd = cmdHit && (busCmd == AIA_CMD_ERR_READ);
			assign evtReadCmd = cmdHit && (busCmd == AIA_CMD_EVT_READ);
			assign stopClrCmd = cmdHit && (busCmd == AIA_CMD_STOP_CLR);
			assign compClrCmd = cmdHit && (busCmd == AIA_CMD_COMP_CLR);
			assign statusRd = bus.rd && hit(bus.addr, g, AIA_OFF_STATUS);

			assign causeInh = cfg_reg[g][AIA_CFG_CAUSE_INH];
			assign statInh = cfg_reg[g][AIA_CFG_STAT_INH];
			assign stopEn = cfg_reg[g][AIA_CFG_STOP_EN];
			assign suppress = cfg_reg[g][AIA_CFG_SUPPRESS];

			// read clear lands one cycle late, inside three
			assign autoClr = statusRead_reg[g] && !statInh;

			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					cfg_reg[g] <= AIA_ZERO;
				end else if (cfgWr) begin
					cfg_reg[g] <= bus.wdata;
				end
			end

			// enable word picks which conditions may set a bit
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					evtEnable_reg[g] <= AIA_EVT_W'(AIA_ZERO);
				end else if (enableWr) begin
					evtEnable_reg[g] <= bus.wdata[AIA_EVT_W-1:0];
				end
			end

			// read command clears only the bits it copies
			always_comb begin
				errClr = AIA_ERR_W'(AIA_ZERO);
				if (errW1c) begin
					errClr = bus.wdata[AIA_ERR_W-1:0];
				end
				if (errReadCmd && !causeInh) begin
					errClr = errClr | errCause_reg[g];
				end
			end

			// set wins, so a same-cycle event is never lost
			assign errCause_next = (errCause_reg[g] & ~errClr) | axisEv[g].errCond;

			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					errCause_reg[g] <= AIA_ERR_W'(AIA_ZERO);
				end else begin
					errCause_reg[g] <= errCause_next;
				end
			end

			// same clear rules as the error causes
			always_comb begin
				evtClr = AIA_EVT_W'(AIA_ZERO);
				if (evtW1c) begin
					evtClr = bus.wdata[AIA_EVT_W-1:0];
				end
				if (evtReadCmd && !causeInh) begin
					evtClr = evtClr | evtCause_reg[g];
				end
			end

			// disabled conditions never reach the cause word
			assign evtCause_next = (evtCause_reg[g] & ~evtClr)
				| (axisEv[g].evtCond & evtEnable_reg[g]);

			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					evtCause_reg[g] <= AIA_EVT_W'(AIA_ZERO);
				end else begin
					evtCause_reg[g] <= evtCause_next;
				end
			end

			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					statusRead_reg[g] <= 1'b0;
				end else begin
					statusRead_reg[g] <= statusRd;
				end
			end

			// chained stops leave the flag alone
			assign setStop = axisEv[g].opStop && stopEn
				&& !contStopOf(suppress, axisEv[g].preregisterState);

			// command clear ignores the read-clear mode
			always_comb begin
				stopFlag_next = stopFlag_reg[g];
				if (setStop) begin
					stopFlag_next = 1'b1;
				end else if (stopClrCmd || autoClr) begin
					stopFlag_next = 1'b0;
				end
			end

			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					stopFlag_reg[g] <= 1'b0;
				end else begin
					stopFlag_reg[g] <= stopFlag_next;
				end
			end

			// companion flag has its own clear command
			always_comb begin
				compFlag_next = compFlag_reg[g];
				if (axisEv[g].compEvent) begin
					compFlag_next = 1'b1;
				end else if (compClrCmd || autoClr) begin
					compFlag_next = 1'b0;
				end
			end

			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					compFlag_reg[g] <= 1'b0;
				end else begin
					compFlag_reg[g] <= compFlag_next;
				end
			end

			// summaries follow the cause words directly
			assign errSummary[g] = |errCause_reg[g];
			assign evtSummary[g] = |evtCause_reg[g];

			// mask hides the axis from irq_n and irq only
			assign pend[g] = !cfg_reg[g][AIA_CFG_PIN_MASK]
				&& (stopFlag_reg[g] || errSummary[g] || evtSummary[g]);
		end
	endgenerate

	// Main status of the addressed axis
	always_comb begin
		statusSel = AIA_ZERO;
		statusSel[AIA_ST_STOP] = stopFlag_reg[busAxis];
		statusSel[AIA_ST_ERR] = errSummary[busAxis];
		statusSel[AIA_ST_EVT] = evtSummary[busAxis];
		statusSel[AIA_ST_COMP] = compFlag_reg[busAxis];
	end

	assign irqNext = |pend;

	// unmask re-drives low, giving a fresh edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_n <= 1'b1;
		end else begin
			irq_n <= !irqNext;
		end
	end

	// always driven; there is no release state to share a wire
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= irqNext;
		end
	end

	// Cause read commands pick the word for the addressed axis
	always_comb begin
		ioBuffer_next = ioBuffer;
		ioBufferValid_next = 1'b0;
		if (cmdWr && (busCmd == AIA_CMD_ERR_READ)) begin
			ioBuffer_next = errWord(errCause_reg[busAxis]);
			ioBufferValid_next = 1'b1;
		end
		if (cmdWr && (busCmd == AIA_CMD_EVT_READ)) begin
			ioBuffer_next = evtWord(evtCause_reg[busAxis]);
			ioBufferValid_next = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ioBuffer <= AIA_ZERO;
		end else begin
			ioBuffer <= ioBuffer_next;
		end
	end

	// Valid pulse lasts one cycle so a host can latch the copy
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ioBuffer_valid <= 1'b0;
		end else begin
			ioBuffer_valid <= ioBufferValid_next;
		end
	end

	// Unmapped offsets read zero; idle cycles too, so stale data never shows
	always_comb begin
		rdata_next = AIA_ZERO;
		if (bus.rd) begin
			unique case (busOff)
				AIA_OFF_STATUS: begin
					rdata_next = statusSel;
				end
				AIA_OFF_CFG: begin
					rdata_next = cfg_reg[busAxis];
				end
				AIA_OFF_ENABLE: begin
					rdata_next = evtWord(evtEnable_reg[busAxis]);
				end
				AIA_OFF_ERRCAUSE: begin
					rdata_next = errWord(errCause_reg[busAxis]);
				end
				AIA_OFF_EVTCAUSE: begin
					rdata_next = evtWord(evtCause_reg[busAxis]);
				end
				default: begin
					rdata_next = AIA_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= AIA_ZERO;
		end else begin
			rdata <= rdata_next;
		end
	end
endmodule // aia_aggregator

/* bench/aia_host_model.sv */
// Purpose: edge-triggered host interrupt input
// Assumes: pin is always driven
// Notes: counts falling edges only
`timescale 1ns/10ps
module aia_host_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic irq_n,
	output logic [7:0] edgeCount
);
	logic prevReg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prevReg <= 1'b1;
			edgeCount <= 8'h00;
		end else begin
			prevReg <= irq_n;
			if (prevReg && !irq_n) edgeCount <= edgeCount + 8'h01;
		end
	end
endmodule // aia_host_model

/* bench/aia_aggregator_asserts.sv */
// Purpose: port checks for the aggregator
// Assumes: config mirrored from bus writes
// Notes: cause checks watch axis 0
`timescale 1ns/10ps
module aia_aggregator_asserts
	import aia_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire aia_axis_ev_t axisEv [AIA_AXES],
	input wire aia_bus_t bus,
	input wire logic [AIA_DATA_W-1:0] rdata,
	input wire logic ioBuffer_valid,
	input wire logic [AIA_DATA_W-1:0] ioBuffer,
	input wire logic irq_n,
	input wire logic irq
);
	logic [31:0] cfgReg [AIA_AXES];
	logic [19:0] enReg;
	logic allMask;
	logic open0;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfgReg <= '{default: AIA_ZERO};
			enReg <= 20'h0_0000;
		end else if (bus.wr) begin
			if (bus.addr[3:0] == 4'h1) cfgReg[bus.addr[5:4]] <= bus.wdata;
			if (bus.addr == 6'h02) enReg <= bus.wdata[19:0];
		end
	end
	assign open0 = !cfgReg[0][AIA_CFG_PIN_MASK];
	assign allMask = cfgReg[0][AIA_CFG_PIN_MASK] & cfgReg[1][AIA_CFG_PIN_MASK]
		& cfgReg[2][AIA_CFG_PIN_MASK] & cfgReg[3][AIA_CFG_PIN_MASK];
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_open; open0 ##1 open0; endsequence
	sequence s_masked; allMask [*2]; endsequence
	property p_copy; irq == !irq_n; endproperty
	a_copy: assert property (p_copy) else $error("irq copy");
	property p_err; |axisEv[0].errCond ##0 s_open |=> !irq_n; endproperty
	a_err: assert property (p_err) else $error("error pin");
	property p_evt; |(axisEv[0].evtCond & enReg) ##0 s_open |=> !irq_n; endproperty
	a_evt: assert property (p_evt) else $error("event pin");
	property p_mask; s_masked |-> irq_n; endproperty
	a_mask: assert property (p_mask) else $error("mask pin");
	property p_fall; $fell(irq_n) |-> !$past(allMask); endproperty
	a_fall: assert property (p_fall) else $error("fall masked");
	property p_rd; !bus.rd |=> rdata == AIA_ZERO; endproperty
	a_rd: assert property (p_rd) else $error("idle rdata");
	property p_buf;
		ioBuffer_valid |-> $past(bus.wr && bus.addr[3:0] == AIA_OFF_CMD && bus.wdata[7:1] == 7'h79);
	endproperty
	a_buf: assert property (p_buf) else $error("buffer cause");
	property p_hold; !ioBuffer_valid |-> $stable(ioBuffer); endproperty
	a_hold: assert property (p_hold) else $error("buffer hold");
endmodule // aia_aggregator_asserts
bind aia_aggregator aia_aggregator_asserts chk (.clk(clk), .rst_n(rst_n), .axisEv(axisEv),
	.bus(bus), .rdata(rdata), .ioBuffer_valid(ioBuffer_valid), .ioBuffer(ioBuffer),
	.irq_n(irq_n), .irq(irq));

/* bench/aia_aggregator_bench.sv */
// Purpose: self-checking bench for the aggregator
// Assumes: edge host model on the pin
// Notes: axes 0 to 2 carry causes
`timescale 1ns/10ps
module aia_aggregator_bench
	import aia_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	aia_axis_ev_t ev [AIA_AXES];
	aia_bus_t bus;
	logic [31:0] rdata, ioBuf, d;
	logic ioVal, irqN, irq;
	logic [7:0] edges;
	int num_errors = 0;
	int compares = 0;
	always #20 clk = ~clk;
	aia_aggregator dut (.clk(clk), .rst_n(rst_n), .axisEv(ev), .bus(bus), .rdata(rdata),
		.ioBuffer_valid(ioVal), .ioBuffer(ioBuf), .irq_n(irqN), .irq(irq));
	aia_host_model host (.clk(clk), .rst_n(rst_n), .irq_n(irqN), .edgeCount(edges));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t %h %h", $time, got, exp);
		end
	endtask
	task wr(input logic [5:0] a, input logic [31:0] v);
		bus <= '{a, v, 1'b1, 1'b0};
		@(posedge clk);
		bus <= '{a, v, 1'b0, 1'b0};
		@(posedge clk);
	endtask
	task rd(input logic [5:0] a, input logic [31:0] exp);
		bus <= '{a, AIA_ZERO, 1'b0, 1'b1};
		@(posedge clk);
		bus <= '{a, AIA_ZERO, 1'b0, 1'b0};
		@(negedge clk);
		chk(rdata, exp);
		@(posedge clk);
	endtask
	task pin(input logic exp);
		@(negedge clk);
		chk({31'h0, irqN}, {31'h0, exp});
		chk({31'h0, irq}, {31'h0, ~exp});
		@(posedge clk);
	endtask
	task pulse(input int ax, input aia_axis_ev_t e);
		ev[ax] <= e;
		@(posedge clk);
		ev[ax] <= '0;
		@(posedge clk);
	endtask
	task t_err;
		pulse(1, '{errCond: 17'h1_0000, default: '0});
		pin(1'b0);
		// summary flag first, then the cause word it names
		rd(6'h10, 32'h0000_0010);
		rd(6'h14, 32'h0001_0000);
		wr(6'h14, 32'h0001_0000);
		rd(6'h10, AIA_ZERO);
		pin(1'b1);
	endtask
	task t_evt;
		pulse(0, '{evtCond: 20'h8_0000, default: '0});
		rd(6'h08, AIA_ZERO);
		wr(6'h02, 32'h0008_0000);
		pulse(0, '{evtCond: 20'h8_0000, default: '0});
		rd(6'h00, 32'h0000_0020);
		wr(6'h0C, 32'h0000_00F3);
		chk(ioBuf, 32'h0008_0000);
		rd(6'h08, AIA_ZERO);
	endtask
	task t_inh;
		wr(6'h01, 32'h0080_0000);
		pulse(0, '{errCond: 17'h0_0001, default: '0});
		wr(6'h0C, 32'h0000_00F2);
		chk(ioBuf, 32'h0000_0001);
		rd(6'h04, 32'h0000_0001);
		wr(6'h04, 32'h0000_0001);
		rd(6'h04, AIA_ZERO);
	endtask
	task t_stop;
		wr(6'h01, AIA_ZERO);
		pulse(0, '{opStop: 1'b1, default: '0});
		rd(6'h00, AIA_ZERO);
		wr(6'h01, 32'h0800_0000);
		pulse(0, '{opStop: 1'b1, preregisterState: AIA_PFM_DONE_A, default: '0});
		rd(6'h00, 32'h0000_0004);
		repeat (2) @(posedge clk);
		rd(6'h00, AIA_ZERO);
		wr(6'h01, 32'h0A00_0000);
		pulse(0, '{opStop: 1'b1, compEvent: 1'b1, default: '0});
		rd(6'h00, 32'h0000_0044);
		repeat (2) @(posedge clk);
		rd(6'h00, 32'h0000_0044);
		wr(6'h0C, {24'h00_0000, AIA_CMD_STOP_CLR});
		rd(6'h00, 32'h0000_0040);
		wr(6'h0C, {24'h00_0000, AIA_CMD_COMP_CLR});
		rd(6'h00, AIA_ZERO);
	endtask
	task t_supp;
		wr(6'h01, 32'h0A00_0080);
		pulse(0, '{opStop: 1'b1, preregisterState: AIA_PFM_DONE_B, default: '0});
		rd(6'h00, AIA_ZERO);
		pulse(0, '{opStop: 1'b1, default: '0});
		rd(6'h00, 32'h0000_0004);
		wr(6'h0C, {24'h00_0000, AIA_CMD_STOP_CLR});
	endtask
	task t_mask;
		pulse(2, '{errCond: 17'h0_0020, default: '0});
		pin(1'b0);
		for (int i = 0; i < AIA_AXES; i++) wr(6'(16 * i + 1), 32'h2000_0000);
		pin(1'b1);
		rd(6'h24, 32'h0000_0020);
		d = {24'h00_0000, edges};
		for (int i = 0; i < AIA_AXES; i++) wr(6'(16 * i + 1), AIA_ZERO);
		pin(1'b0);
		@(negedge clk);
		chk({24'h00_0000, edges}, d + 32'h0000_0001);
		wr(6'h24, 32'h0000_0020);
		rd(6'h24, AIA_ZERO);
		pin(1'b1);
	endtask
	task final_report;
		$display("errors=%0d compares=%0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		bus = '0;
		foreach (ev[i]) ev[i] = '0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_err;
		t_evt;
		t_inh;
		t_stop;
		t_supp;
		t_mask;
		final_report;
	end
	// Whole run is about 120 cycles
	initial begin
		#100000;
		num_errors++;
		final_report;
	end
endmodule // aia_aggregator_bench
